// *** pkg/ssp_defines.svh ***
// constants for the stepper step and phase sequencer
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_SYS_CLK_HZ 10000000
`define SSP_STEP_CLK_HZ 2000000
`define SSP_TICK_DIV (`SSP_SYS_CLK_HZ / `SSP_STEP_CLK_HZ)
`define SSP_TICK_LAST 3'h4

`define SSP_PRESCALE_W 8
`define SSP_PRESCALE_TOP 8'hFF
`define SSP_INTERVAL_W 4
`define SSP_INTERVAL_PRE_TOP 4'h7
`define SSP_INTERVAL_TOP_BIT 3

`define SSP_PRESCALE_US 128
`define SSP_PRESCALE_CYCLES (`SSP_PRESCALE_US * (`SSP_SYS_CLK_HZ / 1000000))
`define SSP_PULSE2_NS 500
`define SSP_PULSE2_CYCLES ((`SSP_PULSE2_NS * (`SSP_SYS_CLK_HZ / 1000000)) / 1000)

`define SSP_PHASE_RESET 2'h0
`define SSP_PULSE_RESET 1'b1
`define SSP_WINDING_OFF 4'h0
`define SSP_WINDING_ONE 4'h1

`endif

// *** pkg/ssp_pkg.sv ***
// types shared by the stepper sequencer modules
package ssp_pkg;
  typedef logic [1:0] ssp_phase_t;
  typedef logic [3:0] ssp_winding_t;
  typedef logic [7:0] ssp_prescale_t;
  typedef logic [3:0] ssp_interval_t;
  typedef logic [2:0] ssp_tick_t;
endpackage

// *** logic/ssp_phase_counter.sv ***
// two-bit up/down phase counter for one drive's stepper motor
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_phase_counter
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // step control
  input wire logic advance,
  input wire logic count_down,
  // counter state
  output logic phase_count_bit0,
  output logic phase_count_bit1
);

  ssp_phase_t phase;
  ssp_phase_t next_phase;

  always_comb begin
    if (count_down) begin
      next_phase = ssp_phase_t'(phase - 2'h1);
    end else begin
      next_phase = ssp_phase_t'(phase + 2'h1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= `SSP_PHASE_RESET;
    end else if (advance) begin
      phase <= next_phase;
    end
  end

  assign phase_count_bit0 = phase[0];
  assign phase_count_bit1 = phase[1];

  a_phase_reset: assert property (@(posedge clk_sys) rst |=> phase == 2'h0)
    else $error("phase counter not cleared by reset");

  a_phase_first: assert property (@(posedge clk_sys) disable iff (rst)
    advance && !count_down && phase == 2'h0 |=> phase == 2'h1)
    else $error("first step from phase 0 did not reach phase 1");

  a_phase_up: assert property (@(posedge clk_sys) disable iff (rst)
    advance && !count_down |=> phase == ssp_phase_t'($past(phase) + 2'h1))
    else $error("phase did not count up toward track 00");

  a_phase_down: assert property (@(posedge clk_sys) disable iff (rst)
    advance && count_down && phase == 2'h0 |=> phase == 2'h3)
    else $error("phase 0 not followed by phase 3 toward track 76");

  a_phase_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !advance |=> phase == $past(phase))
    else $error("phase changed without a step");

endmodule // ssp_phase_counter

// *** logic/ssp_sequencer.sv ***
// step pulse doubler, drive gating, phase decode and winding drive for two drives
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_sequencer
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controller step and direction, asynchronous
  input wire logic step_req,
  input wire logic head_dir,
  // drive selection and status, asynchronous
  input wire logic drive_one_select_n,
  input wire logic controller_running,
  input wire logic track_zero_sense_n,
  input wire logic supply_settle_clear_n,
  // motor pulse and home indication
  output logic motor_step,
  output logic home_n,
  output logic winding_disable,
  // phase counter state
  output logic phase_count_bit0,
  output logic phase_count_bit1,
  output logic drive1_count_bit0,
  output logic drive1_count_bit1,
  // winding drives, one-hot per drive while enabled, all off otherwise
  output ssp_winding_t winding_drv0,
  output ssp_winding_t winding_drv1
);

  // synchronisers: first stage read only by the second
  logic step_meta;
  logic step_sync;
  logic step_prev;
  logic dir_meta;
  logic dir_sync;
  logic sel_meta;
  logic sel_sync;
  logic run_meta;
  logic run_sync;
  logic trk_meta;
  logic trk_sync;
  logic settle_meta;
  logic settle_sync;

  // 2 MHz timing tick derived from the system clock
  ssp_tick_t tick_cnt;
  logic tick;

  // delay sequence state
  logic arm;
  ssp_prescale_t prescaler;
  ssp_interval_t interval;
  logic inter;
  logic pulse_n;

  // events
  logic step_rise;
  logic prescale_wrap;
  logic int_top_rise;
  logic inter_fall;
  logic pulse_fall;
  logic advance_any;
  logic advance_drv0;
  logic advance_drv1;

  // phase state of each drive and of the selected one
  ssp_phase_t phase_drv0;
  ssp_phase_t phase_drv1;
  logic sel_phase0;
  logic winding_enable;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_meta <= 1'b0;
      step_sync <= 1'b0;
      step_prev <= 1'b0;
    end else begin
      step_meta <= step_req;
      step_sync <= step_meta;
      step_prev <= step_sync;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
      sel_meta <= 1'b1;
      sel_sync <= 1'b1;
      run_meta <= 1'b0;
      run_sync <= 1'b0;
      trk_meta <= 1'b1;
      trk_sync <= 1'b1;
      settle_meta <= 1'b0;
      settle_sync <= 1'b0;
    end else begin
      dir_meta <= head_dir;
      dir_sync <= dir_meta;
      sel_meta <= drive_one_select_n;
      sel_sync <= sel_meta;
      run_meta <= controller_running;
      run_sync <= run_meta;
      trk_meta <= track_zero_sense_n;
      trk_sync <= trk_meta;
      settle_meta <= supply_settle_clear_n;
      settle_sync <= settle_meta;
    end
  end

  assign step_rise = step_sync & ~step_prev;

  // tick divider stands in for the 2 MHz counter clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt <= 3'h0;
    end else if (tick) begin
      tick_cnt <= 3'h0;
    end else begin
      tick_cnt <= ssp_tick_t'(tick_cnt + 3'h1);
    end
  end

  assign tick = (tick_cnt == `SSP_TICK_LAST);

  // prescaler top bit falls on wrap
  assign prescale_wrap = arm & tick & (prescaler == `SSP_PRESCALE_TOP);
  assign int_top_rise = prescale_wrap & (interval == `SSP_INTERVAL_PRE_TOP);
  assign inter_fall = inter & int_top_rise;
  // pulse flop clears with arm off and interval top high
  assign pulse_fall = tick & pulse_n & ~arm & interval[`SSP_INTERVAL_TOP_BIT];

  // set arm flag; a new step wins over the release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arm <= 1'b0;
    end else if (step_rise) begin
      arm <= 1'b1;
    end else if (inter_fall) begin
      arm <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    // arm clear holds prescaler at zero
    if (rst || !arm || step_rise) begin
      prescaler <= 8'h00;
    end else if (tick) begin
      prescaler <= ssp_prescale_t'(prescaler + 8'h01);
    end
  end

  // interval counter advances on prescaler wrap
  always_ff @(posedge clk_sys) begin
    if (rst || !pulse_n) begin
      interval <= 4'h0;
    end else if (step_rise) begin
      interval <= 4'h0;
    end else if (prescale_wrap) begin
      interval <= ssp_interval_t'(interval + 4'h1);
    end
  end

  // first top-bit rise sets intermediate flag
  always_ff @(posedge clk_sys) begin
    if (rst || !arm || step_rise) begin
      inter <= 1'b0;
    end else if (int_top_rise) begin
      inter <= ~inter;
    end
  end

  // pulse flop follows its D input on each tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulse_n <= `SSP_PULSE_RESET;
    end else if (tick) begin
      pulse_n <= ~(~arm & interval[`SSP_INTERVAL_TOP_BIT]);
    end
  end

  // home blocks every step toward the motor
  assign advance_any = home_n & (step_rise | pulse_fall);
  // select high routes to drive 0
  assign advance_drv0 = advance_any & sel_sync;
  assign advance_drv1 = advance_any & ~sel_sync;

  ssp_phase_counter u_phase_drv0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .advance(advance_drv0),
    .count_down(dir_sync),
    .phase_count_bit0(phase_count_bit0),
    .phase_count_bit1(phase_count_bit1)
  );

  ssp_phase_counter u_phase_drv1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .advance(advance_drv1),
    .count_down(dir_sync),
    .phase_count_bit0(drive1_count_bit0),
    .phase_count_bit1(drive1_count_bit1)
  );

  // bit0 is select A, bit1 is select B
  assign phase_drv0 = {phase_count_bit1, phase_count_bit0};
  assign phase_drv1 = {drive1_count_bit1, drive1_count_bit0};
  assign sel_phase0 = sel_sync ? (phase_drv0 == 2'h0) : (phase_drv1 == 2'h0);

  // home low on track zero, toward 00, phase 0
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      home_n <= 1'b1;
    end else begin
      home_n <= ~(~trk_sync & ~dir_sync & sel_phase0);
    end
  end

  // motor pulse: the step itself, then the delayed half-step
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      motor_step <= 1'b0;
    end else begin
      motor_step <= home_n & (step_sync | ~pulse_n);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      winding_disable <= 1'b0;
    end else begin
      winding_disable <= ~run_sync;
    end
  end

  assign winding_enable = settle_sync & ~winding_disable;

  // one-hot decode of each drive's phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      winding_drv0 <= `SSP_WINDING_OFF;
      winding_drv1 <= `SSP_WINDING_OFF;
    end else if (!winding_enable) begin
      winding_drv0 <= `SSP_WINDING_OFF;
      winding_drv1 <= `SSP_WINDING_OFF;
    end else begin
      winding_drv0 <= ssp_winding_t'(`SSP_WINDING_ONE << phase_drv0);
      winding_drv1 <= ssp_winding_t'(`SSP_WINDING_ONE << phase_drv1);
    end
  end

  // checks on the sequence
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_pulse_low;
    (!pulse_n) [*5];
  endsequence

  sequence s_pulse_back;
    s_pulse_low ##1 pulse_n;
  endsequence

  a_arm_on_step: assert property (step_rise |=> arm)
    else $error("step request did not arm the delay");

  a_first_pulse: assert property (step_rise && home_n |=> motor_step)
    else $error("first pulse missing at motor output");

  a_prescale_idle: assert property (!arm |=> prescaler == 8'h00 || arm)
    else $error("prescaler counted while not armed");

  a_interval_step: assert property (
    prescale_wrap && pulse_n && !step_rise |=> interval == ssp_interval_t'($past(interval) + 4'h1))
    else $error("interval counter missed a prescaler wrap");

  a_inter_set: assert property (
    int_top_rise && !inter && !step_rise |=> inter && arm)
    else $error("intermediate flag not set at first top-bit rise");

  a_arm_release: assert property (inter_fall && !step_rise |=> !arm ##1 !inter)
    else $error("arm not released when intermediate flag cleared");

  a_pulse_clear: assert property (
    $fell(pulse_n) |-> $past(!arm) ##1 interval == 4'h0)
    else $error("pulse flop fell without release or interval not cleared");

  a_pulse_width: assert property ($fell(pulse_n) |-> s_pulse_back)
    else $error("second pulse not one tick wide");

  a_pulse_out: assert property ($fell(pulse_n) && home_n |=> motor_step)
    else $error("second pulse missing at motor output");

  a_restart: assert property (step_rise |=> interval == 4'h0 && !inter)
    else $error("new step did not restart the sequence");

  a_home_block: assert property (
    !home_n |=> !motor_step && phase_drv0 == $past(phase_drv0) && phase_drv1 == $past(phase_drv1))
    else $error("step passed while home is low");

  a_drive_gate: assert property (
    advance_any && sel_sync |=> {drive1_count_bit1, drive1_count_bit0} == $past(phase_drv1))
    else $error("step reached the unselected drive");

  a_drive0_gate: assert property (
    advance_any && !sel_sync |=> phase_drv0 == $past(phase_drv0))
    else $error("step reached drive 0 while drive 1 selected");

  a_winding_onehot: assert property (winding_enable |=> $onehot(winding_drv0) && $onehot(winding_drv1))
    else $error("winding decode not one-hot");

  a_winding_map: assert property (
    winding_enable |=> winding_drv0 == ssp_winding_t'(`SSP_WINDING_ONE << $past(phase_drv0)))
    else $error("winding does not match phase value");

  a_winding_off: assert property (winding_disable |=> winding_drv0 == 4'h0 && winding_drv1 == 4'h0)
    else $error("winding on while disabled");

  a_settle_hold: assert property (!settle_sync |=> winding_drv0 == 4'h0 && winding_drv1 == 4'h0)
    else $error("winding on before supply settled");

  a_home_cause: assert property (
    !trk_sync && !dir_sync && sel_phase0 |=> !home_n)
    else $error("home not asserted at track zero");

endmodule // ssp_sequencer

// *** tb/ssp_ctrl_model.sv ***
// controller-side model that issues step pulses and head direction
`timescale 1ns/10ps
module ssp_ctrl_model #(
  parameter int STEP_W = 40
) (
  // clock
  input wire logic clk_sys,
  // commands from the bench
  input wire logic fire,
  input wire logic dir_cmd,
  // lines toward the sequencer
  output logic step_req,
  output logic head_dir
);
  int cnt = 0;
  // direction level, moved just after an edge
  always @(posedge clk_sys) begin
    head_dir <= dir_cmd;
  end
  always @(posedge clk_sys) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (fire) begin
      cnt <= STEP_W;
    end
  end
  assign step_req = (cnt != 0);
endmodule // ssp_ctrl_model

// *** tb/ssp_sequencer_tb.sv ***
// self-checking bench for the stepper step and phase sequencer
`timescale 1ns/10ps
module ssp_sequencer_tb;
  import ssp_pkg::*;
  // arm to second pulse: 24 prescaler periods of 256 ticks of 5 clk
  localparam int SEQ_CLK = 24 * 256 * 5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic fire = 1'b0;
  logic dir_cmd = 1'b0;
  logic drive_one_select_n = 1'b1;
  logic controller_running = 1'b1;
  logic track_zero_sense_n = 1'b1;
  logic supply_settle_clear_n = 1'b0;
  logic step_req, head_dir, motor_step, home_n, winding_disable;
  logic p0b0, p0b1, p1b0, p1b1;
  ssp_winding_t winding_drv0, winding_drv1;
  int fail_count = 0;
  int check_count = 0;
  int ph[2] = '{0, 0};
  logic [31:0] seed = 32'h0000_b960;

  ssp_ctrl_model u_ctrl (.clk_sys(clk_sys), .fire(fire), .dir_cmd(dir_cmd), .step_req(step_req),
    .head_dir(head_dir));
  ssp_sequencer u_dut (.clk_sys(clk_sys), .rst(rst), .step_req(step_req), .head_dir(head_dir),
    .drive_one_select_n(drive_one_select_n), .controller_running(controller_running),
    .track_zero_sense_n(track_zero_sense_n), .supply_settle_clear_n(supply_settle_clear_n),
    .motor_step(motor_step), .home_n(home_n), .winding_disable(winding_disable),
    .phase_count_bit0(p0b0), .phase_count_bit1(p0b1), .drive1_count_bit0(p1b0),
    .drive1_count_bit1(p1b1), .winding_drv0(winding_drv0), .winding_drv1(winding_drv1));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic ssp_winding_t exp_wind(int p);
    return (controller_running && supply_settle_clear_n) ? ssp_winding_t'(1 << p) : 4'h0;
  endfunction

  function automatic logic exp_home();
    return !(!track_zero_sense_n && !dir_cmd && ph[drive_one_select_n ? 0 : 1] == 0);
  endfunction

  task automatic fail(string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk_phase(logic [1:0] got, int exp, string m);
    check_count++;
    if (got !== ssp_phase_t'(exp)) fail(m);
  endtask

  task automatic chk_wind(ssp_winding_t got, ssp_winding_t exp, string m);
    check_count++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_flag(logic got, logic exp, string m);
    check_count++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_num(int got, int lo, int hi, string m);
    check_count++;
    if (got < lo || got > hi) fail(m);
  endtask

  task automatic cycles(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check_all();
    chk_phase({p0b1, p0b0}, ph[0], "drive 0 phase");
    chk_phase({p1b1, p1b0}, ph[1], "drive 1 phase");
    chk_wind(winding_drv0, exp_wind(ph[0]), "drive 0 windings");
    chk_wind(winding_drv1, exp_wind(ph[1]), "drive 1 windings");
    chk_flag(home_n, exp_home(), "home level");
    chk_flag(winding_disable, !controller_running, "disable level");
  endtask

  // one controller step; width of the first motor pulse is counted
  task automatic do_step(logic dir, logic sel_n);
    int hi;
    int d;
    logic go;
    hi = 0;
    dir_cmd = dir;
    drive_one_select_n = sel_n;
    cycles(6);
    d = sel_n ? 0 : 1;
    go = exp_home();
    fire = 1'b1;
    cycles(1);
    fire = 1'b0;
    repeat (60) begin
      @(negedge clk_sys);
      hi += (motor_step === 1'b1);
    end
    if (go) ph[d] = (ph[d] + (dir ? 3 : 1)) % 4;
    chk_num(hi, go ? 40 : 0, go ? 40 : 0, "first pulse width");
    check_all();
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #5_000_000;
    fail("watchdog expired");
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic [1:0] p;
    int n;
    cycles(10);
    rst = 1'b0;
    cycles(8);
    check_all();
    supply_settle_clear_n = 1'b1;
    cycles(8);
    check_all();
    track_zero_sense_n = 1'b0;
    cycles(8);
    check_all();
    do_step(1'b0, 1'b1);
    do_step(1'b1, 1'b1);
    track_zero_sense_n = 1'b1;
    // random direction and drive, spaced well inside the delay so each restarts it
    for (int i = 0; i < 12; i++) begin
      r = xs();
      do_step(r[0], r[1]);
    end
    do_step(1'b0, 1'b1);
    p = {p0b1, p0b0};
    n = 0;
    while (n < 32000 && {p0b1, p0b0} === p) begin
      @(negedge clk_sys);
      n++;
    end
    chk_num(n + 61, SEQ_CLK - 20, SEQ_CLK + 20, "second pulse delay");
    ph[0] = (ph[0] + 1) % 4;
    n = 0;
    repeat (20) begin
      @(negedge clk_sys);
      n += (motor_step === 1'b1);
    end
    chk_num(n, 5, 5, "second pulse width");
    check_all();
    for (int k = 0; k < 4; k++) begin
      controller_running = k[0];
      supply_settle_clear_n = k[1];
      cycles(8);
      check_all();
    end
    print_verdict();
  end
endmodule // ssp_sequencer_tb
